// ===== trace_caps_defines.svh
/*
 Constants for the trace capability identification register bank:
 system-register encodings, field positions, fixed field codes, levels.
 Assumes inclusion by bare name from the bank and its ROM module.
*/
`ifndef TRACE_CAPS_DEFINES_SVH
`define TRACE_CAPS_DEFINES_SVH

// ---------------------------------------------------------------
// Encodings
// ---------------------------------------------------------------
`define TC_OP0              2'h2
`define TC_OP1              3'h1
`define TC_CRN              4'h0
`define TC_CRM_MAIN         4'hd
`define TC_OP2_MAIN         3'h7
`define TC_CRM_RES_A        4'h2
`define TC_CRM_RES_B        4'h3
`define TC_CRM_RES_C        4'h4
`define TC_OP2_RES          3'h6

// ---------------------------------------------------------------
// Fields of the main register
// ---------------------------------------------------------------
`define TC_CNT_HI           30
`define TC_CNT_LO           28
`define TC_CNT_VAL          3'h2
`define TC_SEQ_HI           27
`define TC_SEQ_LO           25
`define TC_SEQ_VAL          3'h4
`define TC_LPO_BIT          23
`define TC_LPO_VAL          1'h0
`define TC_TRIG_BIT         22
`define TC_TRIG_VAL         1'h1
`define TC_TID_HI           21
`define TC_TID_LO           16
`define TC_TID_VAL          6'h07
`define TC_SEL_HI           11
`define TC_SEL_LO           9
`define TC_SEL_VAL          3'h4
`define TC_EXT_HI           8
`define TC_EXT_LO           0
`define TC_EXT_VAL          9'h0ff
`define TC_RESET_VALUE      64'h0000_0000_0000_0000

// ---------------------------------------------------------------
// Levels and syndrome
// ---------------------------------------------------------------
`define TC_LVL0             2'h0
`define TC_LVL1             2'h1
`define TC_LVL2             2'h2
`define TC_LVL3             2'h3
`define TC_SYNDROME_CLASS   6'h18

`endif

// ===== trace_caps_pkg.sv
/*
 Types for the trace capability identification register bank.
 Assumes the defines header is on the include path.
*/
package trace_caps_pkg;

   typedef enum logic [1:0] {
      OUT_DATA,
      OUT_UNDEF,
      OUT_TRAP
   } outcome_t;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_MAIN,
      SEL_RES_A,
      SEL_RES_B,
      SEL_RES_C
   } reg_sel_t;

endpackage : trace_caps_pkg

// ===== trace_caps_rom.sv
/*
 Fixed-value table of the four capability registers; registered output.
 Assumes a synchronous active-high reset and one clock.
*/
`timescale 1ns/1ps
`include "trace_caps_defines.svh"

module trace_caps_rom #(
   parameter int WIDTH = 64
) (
   input  wire logic                     mclk,
   input  wire logic                     srst,
   input  wire trace_caps_pkg::reg_sel_t sel,
   output logic [WIDTH-1:0]              rdata
);

   logic [WIDTH-1:0] main_value;

   // ---------------------------------------------------------------
   // Main register value
   // ---------------------------------------------------------------
   always_comb begin
      main_value = `TC_RESET_VALUE;
      main_value[`TC_CNT_HI:`TC_CNT_LO] = `TC_CNT_VAL;
      main_value[`TC_SEQ_HI:`TC_SEQ_LO] = `TC_SEQ_VAL;
      main_value[`TC_LPO_BIT]           = `TC_LPO_VAL;
      main_value[`TC_TRIG_BIT]          = `TC_TRIG_VAL;
      main_value[`TC_TID_HI:`TC_TID_LO] = `TC_TID_VAL;
      main_value[`TC_SEL_HI:`TC_SEL_LO] = `TC_SEL_VAL;
      main_value[`TC_EXT_HI:`TC_EXT_LO] = `TC_EXT_VAL;
   end

   // ---------------------------------------------------------------
   // Registered read
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata <= `TC_RESET_VALUE;
      end else begin
         case (sel)
            trace_caps_pkg::SEL_MAIN:  rdata <= main_value;
            trace_caps_pkg::SEL_RES_A: rdata <= `TC_RESET_VALUE;
            trace_caps_pkg::SEL_RES_B: rdata <= `TC_RESET_VALUE;
            trace_caps_pkg::SEL_RES_C: rdata <= `TC_RESET_VALUE;
            default:                   rdata <= `TC_RESET_VALUE;
         endcase
      end
   end

endmodule : trace_caps_rom

// ===== trace_capability_id_regs.sv
/*
 Read-only trace capability identification registers with the
 privilege and trap checks of a system-register read.
 Assumes requests are single-cycle pulses synchronous to mclk and that
 trap-control levels are stable while a read is issued.
*/
// Contract
// - Counter count field reads two counters
// - Sequencer field reads four states
// - Low-power override support reads zero
// - Trace-bus trigger support reads one
// - Trace identifier width reads seven bits
// - Four external input selectors reported
// - External input count reads code 0x0ff
// - Main register selected by its encoding
// - Tenth register reads all zero
// - Tenth register selected by its encoding
// - Eleventh register reads all zero
// - Eleventh register selected by its encoding
// - Twelfth register reads all zero
// - Twelfth register selected by its encoding
// - Least privileged level read is undefined
// - Level-one trap bit traps to level one
// - Hypervisor trap bit traps level one reads
// - Fine-grained trace-ID trap goes to hypervisor
// - Hypervisor reads trap on its trap bit
// - Monitor trap bit traps, else data returned
// - Main register is 64 bits wide
`timescale 1ns/1ps
`include "trace_caps_defines.svh"

module trace_capability_id_regs #(
   parameter int WIDTH = 64
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic             read_req,
   input  wire logic [1:0]       op0,
   input  wire logic [2:0]       op1,
   input  wire logic [3:0]       crn,
   input  wire logic [3:0]       crm,
   input  wire logic [2:0]       op2,
   input  wire logic [1:0]       current_exception_level,
   input  wire logic             hypervisor_enabled,
   input  wire logic             level_one_trace_access_trap,
   input  wire logic             hypervisor_trace_access_trap,
   input  wire logic             monitor_trace_access_trap,
   input  wire logic             fine_grained_trap_enable,
   input  wire logic             fine_grained_trace_id_read_trap,
   output logic                  read_done,
   output logic                  read_hit,
   output logic [WIDTH-1:0]      read_data,
   output logic                  undefined_instr,
   output logic                  trap_taken,
   output logic [1:0]            trap_target_level,
   output logic [5:0]            trap_syndrome_class
);

   trace_caps_pkg::reg_sel_t sel;
   trace_caps_pkg::reg_sel_t rom_sel;
   trace_caps_pkg::outcome_t outcome;
   logic [1:0]               target;
   logic                     common;
   logic [WIDTH-1:0]         rom_data;
   logic                     pend_data;

   // ---------------------------------------------------------------
   // Encoding decode
   // ---------------------------------------------------------------
   always_comb begin
      common = (op0 == `TC_OP0) && (op1 == `TC_OP1) && (crn == `TC_CRN);
      sel    = trace_caps_pkg::SEL_NONE;
      if (common && crm == `TC_CRM_MAIN && op2 == `TC_OP2_MAIN) begin
         sel = trace_caps_pkg::SEL_MAIN;
      end else if (common && crm == `TC_CRM_RES_A && op2 == `TC_OP2_RES) begin
         sel = trace_caps_pkg::SEL_RES_A;
      end else if (common && crm == `TC_CRM_RES_B && op2 == `TC_OP2_RES) begin
         sel = trace_caps_pkg::SEL_RES_B;
      end else if (common && crm == `TC_CRM_RES_C && op2 == `TC_OP2_RES) begin
         sel = trace_caps_pkg::SEL_RES_C;
      end
   end

   // ---------------------------------------------------------------
   // Privilege and trap checks
   // ---------------------------------------------------------------
   always_comb begin
      outcome = trace_caps_pkg::OUT_DATA;
      target  = `TC_LVL0;
      case (current_exception_level)
         `TC_LVL0: begin
            outcome = trace_caps_pkg::OUT_UNDEF;
         end
         `TC_LVL1: begin
            if (level_one_trace_access_trap) begin
               outcome = trace_caps_pkg::OUT_TRAP;
               target  = `TC_LVL1;
            end else if (hypervisor_enabled && hypervisor_trace_access_trap) begin
               outcome = trace_caps_pkg::OUT_TRAP;
               target  = `TC_LVL2;
            end else if (hypervisor_enabled && fine_grained_trap_enable &&
                         fine_grained_trace_id_read_trap) begin
               outcome = trace_caps_pkg::OUT_TRAP;
               target  = `TC_LVL2;
            end else if (monitor_trace_access_trap) begin
               outcome = trace_caps_pkg::OUT_TRAP;
               target  = `TC_LVL3;
            end
         end
         `TC_LVL2: begin
            if (hypervisor_trace_access_trap) begin
               outcome = trace_caps_pkg::OUT_TRAP;
               target  = `TC_LVL2;
            end else if (monitor_trace_access_trap) begin
               outcome = trace_caps_pkg::OUT_TRAP;
               target  = `TC_LVL3;
            end
         end
         default: begin
            if (monitor_trace_access_trap) begin
               outcome = trace_caps_pkg::OUT_TRAP;
               target  = `TC_LVL3;
            end
         end
      endcase
   end

   // Data is only fetched for an accepted read of a mapped register
   assign rom_sel = (read_req && outcome == trace_caps_pkg::OUT_DATA) ?
                    sel : trace_caps_pkg::SEL_NONE;

   trace_caps_rom #(
      .WIDTH (WIDTH)
   ) u_rom (
      .mclk  (mclk),
      .srst  (srst),
      .sel   (rom_sel),
      .rdata (rom_data)
   );

   // ---------------------------------------------------------------
   // Answer registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         read_done           <= 1'b0;
         read_hit            <= 1'b0;
         undefined_instr     <= 1'b0;
         trap_taken          <= 1'b0;
         trap_target_level   <= `TC_LVL0;
         trap_syndrome_class <= 6'h00;
         pend_data           <= 1'b0;
      end else begin
         read_done           <= read_req;
         read_hit            <= read_req && sel != trace_caps_pkg::SEL_NONE;
         undefined_instr     <= read_req && (sel == trace_caps_pkg::SEL_NONE ||
                                outcome == trace_caps_pkg::OUT_UNDEF);
         trap_taken          <= read_req && sel != trace_caps_pkg::SEL_NONE &&
                                outcome == trace_caps_pkg::OUT_TRAP;
         pend_data           <= read_req && sel != trace_caps_pkg::SEL_NONE &&
                                outcome == trace_caps_pkg::OUT_DATA;
         if (read_req && sel != trace_caps_pkg::SEL_NONE &&
             outcome == trace_caps_pkg::OUT_TRAP) begin
            trap_target_level   <= target;
            trap_syndrome_class <= `TC_SYNDROME_CLASS;
         end else begin
            trap_target_level   <= `TC_LVL0;
            trap_syndrome_class <= 6'h00;
         end
      end
   end

   // Data bus shows the table value only when a read completed
   assign read_data = pend_data ? rom_data : `TC_RESET_VALUE;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_main_value_fixed: assert property (@(posedge mclk) disable iff (srst)
      read_req && sel == trace_caps_pkg::SEL_MAIN && current_exception_level == `TC_LVL3
      && !monitor_trace_access_trap |=> read_data[30:28] == 3'h2 && read_data[27:25] == 3'h4)
      else $error("counter or sequencer field wrong");
   a_main_bits_fixed: assert property (@(posedge mclk) disable iff (srst)
      read_req && sel == trace_caps_pkg::SEL_MAIN && outcome == trace_caps_pkg::OUT_DATA
      |=> read_data[21:16] == 6'h07 && read_data[23] == 1'b0 && read_data[22] == 1'b1
      && read_data[11:9] == 3'h4 && read_data[8:0] == 9'h0ff && read_data[63:31] == 33'h0
      && read_data[24] == 1'b0 && read_data[15:12] == 4'h0)
      else $error("main register field wrong");
   a_low_level_undef: assert property (@(posedge mclk) disable iff (srst)
      read_req && current_exception_level == `TC_LVL0 |=> undefined_instr && !trap_taken
      && read_data == 64'h0000_0000_0000_0000)
      else $error("least privileged read not undefined");
   a_lvl1_trap_own: assert property (@(posedge mclk) disable iff (srst)
      read_req && sel != trace_caps_pkg::SEL_NONE && current_exception_level == `TC_LVL1
      && level_one_trace_access_trap |=> trap_taken && trap_target_level == 2'h1
      && trap_syndrome_class == 6'h18)
      else $error("level one trap missing");
   a_lvl1_trap_hyp: assert property (@(posedge mclk) disable iff (srst)
      read_req && sel != trace_caps_pkg::SEL_NONE && current_exception_level == `TC_LVL1
      && !level_one_trace_access_trap && hypervisor_enabled
      && hypervisor_trace_access_trap |=> trap_taken && trap_target_level == 2'h2)
      else $error("hypervisor trap of level one missing");
   a_fine_grain_trap: assert property (@(posedge mclk) disable iff (srst)
      read_req && sel != trace_caps_pkg::SEL_NONE && current_exception_level == `TC_LVL1
      && !level_one_trace_access_trap && hypervisor_enabled && fine_grained_trap_enable
      && fine_grained_trace_id_read_trap |=> trap_taken && trap_target_level == 2'h2)
      else $error("fine-grained trap missing");
   a_lvl2_trap_hyp: assert property (@(posedge mclk) disable iff (srst)
      read_req && sel != trace_caps_pkg::SEL_NONE && current_exception_level == `TC_LVL2
      && hypervisor_trace_access_trap |=> trap_taken && trap_target_level == 2'h2
      && trap_syndrome_class == 6'h18)
      else $error("hypervisor level trap missing");
   a_monitor_or_data: assert property (@(posedge mclk) disable iff (srst)
      read_req && sel == trace_caps_pkg::SEL_RES_A && current_exception_level == `TC_LVL3
      |=> (trap_taken == $past(monitor_trace_access_trap)) && read_hit
      && read_data == 64'h0000_0000_0000_0000)
      else $error("monitor level outcome wrong");
   a_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
      read_req && (sel == trace_caps_pkg::SEL_RES_B || sel == trace_caps_pkg::SEL_RES_C)
      |=> read_data == 64'h0000_0000_0000_0000 && read_hit)
      else $error("reserved register not zero");
   a_trap_no_data: assert property (@(posedge mclk) disable iff (srst)
      trap_taken |-> read_data == 64'h0000_0000_0000_0000 && !undefined_instr)
      else $error("data shown with a trap");

endmodule : trace_capability_id_regs

// ===== testbench.sv
/*
 Self-checking bench for the trace capability identification bank.
 Assumes the design files are compiled first, one clock, and that inputs
 are driven at the falling edge of mclk.
*/
`timescale 1ns/1ps

module testbench;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        done;
      logic        hit;
      logic [63:0] data;
      logic        undef;
      logic        trap;
      logic [1:0]  tgt;
      logic [5:0]  cls;
   } exp_t;

   localparam int          WIDTH      = 64;
   localparam logic [63:0] main_value = {33'h0, 3'h2, 3'h4, 1'h0, 1'h0, 1'h1,
                                         6'h07, 4'h0, 3'h4, 9'h0ff};

   logic              mclk;
   logic              srst;
   logic              read_req;
   logic [1:0]        op0;
   logic [2:0]        op1;
   logic [3:0]        crn;
   logic [3:0]        crm;
   logic [2:0]        op2;
   logic [1:0]        current_exception_level;
   logic              hypervisor_enabled;
   logic              level_one_trace_access_trap;
   logic              hypervisor_trace_access_trap;
   logic              monitor_trace_access_trap;
   logic              fine_grained_trap_enable;
   logic              fine_grained_trace_id_read_trap;
   logic              read_done;
   logic              read_hit;
   logic [WIDTH-1:0]  read_data;
   logic              undefined_instr;
   logic              trap_taken;
   logic [1:0]        trap_target_level;
   logic [5:0]        trap_syndrome_class;
   logic [15:0]       enc_tab [8];
   exp_t              expv;
   int                bad_count;
   int                check_count;

`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH t=%0t %s got %h exp %h", $time, m, a, b); end end

   // ---------------------------------------------------------------
   // Design and clock
   // ---------------------------------------------------------------
   trace_capability_id_regs #(.WIDTH(WIDTH)) u_trace_capability_id_regs (
      .mclk                            (mclk),
      .srst                            (srst),
      .read_req                        (read_req),
      .op0                             (op0),
      .op1                             (op1),
      .crn                             (crn),
      .crm                             (crm),
      .op2                             (op2),
      .current_exception_level         (current_exception_level),
      .hypervisor_enabled              (hypervisor_enabled),
      .level_one_trace_access_trap     (level_one_trace_access_trap),
      .hypervisor_trace_access_trap    (hypervisor_trace_access_trap),
      .monitor_trace_access_trap       (monitor_trace_access_trap),
      .fine_grained_trap_enable        (fine_grained_trap_enable),
      .fine_grained_trace_id_read_trap (fine_grained_trace_id_read_trap),
      .read_done                       (read_done),
      .read_hit                        (read_hit),
      .read_data                       (read_data),
      .undefined_instr                 (undefined_instr),
      .trap_taken                      (trap_taken),
      .trap_target_level               (trap_target_level),
      .trap_syndrome_class             (trap_syndrome_class)
   );

   always #4 mclk = ~mclk;

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic exp_t model(input logic rq, input logic rs, input logic [15:0] enc,
                                  input logic [1:0] lvl, input logic [5:0] tb);
      exp_t e;
      int   t;
      e = '0;
      t = 0;
      if (rs || !rq) return e;
      e.done = 1'b1;
      if (enc[15:7] == 9'h110) begin
         if (enc[6:0] == {4'hd, 3'h7} || enc[6:0] == {4'h2, 3'h6} ||
             enc[6:0] == {4'h3, 3'h6} || enc[6:0] == {4'h4, 3'h6}) begin
            e.hit = 1'b1;
         end
      end
      if (!e.hit || lvl == 2'h0) begin
         e.undef = 1'b1;
         return e;
      end
      // Trap bits: {hyp enable, level one, hypervisor, monitor, fine enable, fine id}
      if (lvl == 2'h1) begin
         if (tb[4]) t = 1;
         else if (tb[5] && tb[3]) t = 2;
         else if (tb[5] && tb[1] && tb[0]) t = 2;
         else if (tb[2]) t = 3;
      end else if (lvl == 2'h2) begin
         if (tb[3]) t = 2;
         else if (tb[2]) t = 3;
      end else if (tb[2]) begin
         t = 3;
      end
      if (t > 0) begin
         e.trap = 1'b1;
         e.tgt  = t[1:0];
         e.cls  = 6'h18;
      end else if (enc[6:0] == {4'hd, 3'h7}) begin
         e.data = main_value;
      end
      return e;
   endfunction : model

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic step(input logic rq, input logic rs, input logic [15:0] enc,
                       input logic [1:0] lvl, input logic [5:0] tb);
      @(negedge mclk);
      `CHK(read_done, expv.done, "done")
      `CHK(read_hit, expv.hit, "hit")
      `CHK(read_data, expv.data, "data")
      `CHK(undefined_instr, expv.undef, "undef")
      `CHK(trap_taken, expv.trap, "trap")
      `CHK(trap_target_level, expv.tgt, "target")
      `CHK(trap_syndrome_class, expv.cls, "class")
      read_req                 = rq;
      srst                     = rs;
      {op0, op1, crn, crm, op2} = enc;
      current_exception_level  = lvl;
      {hypervisor_enabled, level_one_trace_access_trap, hypervisor_trace_access_trap,
       monitor_trace_access_trap, fine_grained_trap_enable,
       fine_grained_trace_id_read_trap} = tb;
      expv = model(rq, rs, enc, lvl, tb);
   endtask : step

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      srst = 1'b1;
      read_req = 1'b0;
      {op0, op1, crn, crm, op2} = 16'h0000;
      current_exception_level = 2'h0;
      {hypervisor_enabled, level_one_trace_access_trap, hypervisor_trace_access_trap,
       monitor_trace_access_trap, fine_grained_trap_enable,
       fine_grained_trace_id_read_trap} = 6'h00;
      expv = '0;
      bad_count = 0;
      check_count = 0;
      enc_tab[0] = {2'h2, 3'h1, 4'h0, 4'hd, 3'h7};
      enc_tab[1] = {2'h2, 3'h1, 4'h0, 4'h2, 3'h6};
      enc_tab[2] = {2'h2, 3'h1, 4'h0, 4'h3, 3'h6};
      enc_tab[3] = {2'h2, 3'h1, 4'h0, 4'h4, 3'h6};
      enc_tab[4] = {2'h2, 3'h1, 4'h0, 4'hc, 3'h7};
      enc_tab[5] = {2'h2, 3'h1, 4'h0, 4'h5, 3'h6};
      enc_tab[6] = {2'h3, 3'h1, 4'h0, 4'hd, 3'h7};
      enc_tab[7] = {2'h2, 3'h1, 4'h1, 4'h2, 3'h6};
      void'($urandom(32'h0b1a));
      // Reset with reads offered, which must be ignored
      for (int i = 0; i < 20; i++) begin
         step(1'($urandom), 1'b1, enc_tab[$urandom % 8], 2'($urandom), 6'($urandom));
      end
      // One idle cycle after reset before the first read
      step(1'b0, 1'b0, enc_tab[0], 2'h3, 6'h00);
      // Every encoding at every level with every trap setting, back to back
      for (int e = 0; e < 8; e++) begin
         for (int l = 0; l < 4; l++) begin
            for (int t = 0; t < 64; t++) begin
               step(1'b1, 1'b0, enc_tab[e], l[1:0], t[5:0]);
            end
         end
      end
      // Random traffic with gaps, stray encodings and resets in mid-run
      for (int i = 0; i < 3000; i++) begin
         step(1'($urandom) && !srst, 1'(($urandom % 97) == 0),
              (($urandom % 4) == 0) ? 16'($urandom) : enc_tab[$urandom % 8],
              2'($urandom), 6'($urandom));
      end
      for (int i = 0; i < 3; i++) begin
         step(1'b0, 1'b0, enc_tab[0], 2'h3, 6'h00);
      end
      give_verdict();
   end

   initial begin
      #(8 * 20000);
      bad_count++;
      $display("MISMATCH t=%0t run did not finish in time", $time);
      give_verdict();
   end

endmodule : testbench
